// ===== onfe_host.v
// onfe_host.v : host controller for an octal serial NAND front end.
// assumes: AHB-Lite single word transfers; device pins on the far side.
`timescale 1ns/1ps
`include "onfe_defs.vh"
module onfe_host #(
  parameter RST_NS = `ONFE_RST_PULSE_NS
) (
  // clock, reset, enable
  input  wire        ref_clk,
  input  wire        arst_n,
  input  wire        clkEn,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // device pins
  output reg         flashClk,
  output reg         flashSelN,
  output reg         flashRstN,
  output reg  [7:0]  ioOut,
  output reg  [7:0]  ioOe,
  input  wire [7:0]  ioIn,
  input  wire        strobeIn
);
  localparam integer RST_CYC =
    (RST_NS + `ONFE_CLK_NS - 1) / `ONFE_CLK_NS;
  // =====================================================================
  // reset release and pin synchronisers
  reg        rstMeta;
  reg        rstN;
  wire [8:0] pinSync;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta <= 1'b0;
      rstN    <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstN    <= rstMeta;
    end
  end
  onfe_sync #(.W(9)) uSync (
    .clk  (ref_clk),
    .rstN (rstN),
    .ce   (clkEn),
    .din  ({strobeIn, ioIn}),
    .dout (pinSync)
  );
  // =====================================================================
  // registers
  reg [8:0]  ctrl;
  reg [31:0] cmd;
  reg [31:0] addr;
  reg [31:0] wdata;
  reg [31:0] rdata;
  reg [7:0]  divisor;
  reg        busy;
  reg        wrenSeen;
  reg        rstArmed;
  reg        phaseErr;
  reg        apWrite;
  reg        apRead;
  reg [7:0]  apAddr;
  // opcode decoding, used on go and for status
  function isWriteOp;
    input [7:0] op;
    begin
      isWriteOp = (op == 8'h02) || (op == 8'h10) ||
                  (op == 8'hD8) || (op == 8'h01) || (op == 8'h1F);
    end
  endfunction
  function isOctalOp;
    input [7:0] op;
    begin
      isOctalOp = (op == `ONFE_OP_FRO) || (op == `ONFE_OP_FRIO) ||
                  (op == `ONFE_OP_DDRO);
    end
  endfunction
  wire goHit = apWrite && (apAddr == `ONFE_A_CMD) && hwdata[`ONFE_K_GO];
  wire [7:0] goOp = hwdata[7:0];
  // refuse write ops without a prior write enable, and octal when guarded
  wire goBad = (isWriteOp(goOp) && !wrenSeen) ||
               (isOctalOp(goOp) && ctrl[`ONFE_C_WPN]) ||
               (goOp == `ONFE_OP_RST && !rstArmed) ||
               (busy);
  // ahb: zero wait state, always okay
  always @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      apWrite   <= 1'b0;
      apRead    <= 1'b0;
      apAddr    <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else if (clkEn) begin
      apWrite <= hsel && hready && htrans[1] && hwrite;
      apRead  <= hsel && hready && htrans[1] && !hwrite;
      apAddr  <= haddr;
      if (hsel && hready && htrans[1] && !hwrite) begin
        case (haddr)
          `ONFE_A_CTRL:  hrdata <= {23'h0, ctrl};
          `ONFE_A_CMD:   hrdata <= cmd;
          `ONFE_A_ADDR:  hrdata <= addr;
          `ONFE_A_WDATA: hrdata <= wdata;
          `ONFE_A_STAT:  hrdata <= {28'h0, phaseErr, rstArmed, wrenSeen,
                                    busy};
          `ONFE_A_RDATA: hrdata <= rdata;
          `ONFE_A_DIV:   hrdata <= {24'h0, divisor};
          default:       hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  // =====================================================================
  // sequencer
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_DESEL = 3'h1;
  localparam [2:0] S_XFER = 3'h2;
  localparam [2:0] S_END = 3'h3;
  localparam [2:0] S_HWRST = 3'h4;
  reg [2:0]  state;
  reg [7:0]  divCnt;
  reg        edgeHi;
  reg [2:0]  bitCnt;
  reg [3:0]  byteIdx;
  reg [3:0]  byteTot;
  reg [4:0]  dumCnt;
  reg        ddrOn;
  reg        octOn;
  reg [15:0] rstCnt;
  reg        shLoad;
  reg [7:0]  shByte;
  reg        shStep;
  wire [7:0] txLanes;
  wire [7:0] rxByte;
  onfe_shift uShift (
    .clk      (ref_clk),
    .rstN     (rstN),
    .ce       (clkEn),
    .load     (shLoad),
    .loadByte (shByte),
    .octal    (octOn),
    .step     (shStep),
    .sampleIn (pinSync[7:0]),
    .txLanes  (txLanes),
    .rxByte   (rxByte)
  );
  wire       tick = (divCnt == divisor);
  wire [2:0] aLen = cmd[`ONFE_K_ALEN];
  wire       rdOp = cmd[`ONFE_K_READ];
  wire       inRead = rdOp && (byteIdx > {1'b0, aLen});
  // byte as it stands once this sampling step lands
  wire [7:0] rxNow = octOn ? pinSync[7:0] : {rxByte[6:0], pinSync[1]};
  // byte n of the frame: opcode, address msb first, then write data
  function [7:0] frameByte;
    input [3:0]  idx;
    input [2:0]  al;
    input [31:0] c;
    input [31:0] a;
    input [31:0] w;
    reg   [3:0]  k;
    begin
      k = idx - 4'h1;
      if (idx == 4'h0) frameByte = c[7:0];
      else if (k < {1'b0, al}) frameByte = a[8*(al-1-k[2:0]) +: 8];
      else frameByte = w[8*(k[1:0] - al[1:0]) +: 8];
    end
  endfunction
  always @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      state     <= S_DESEL;
      ctrl      <= 9'h000;
      cmd       <= 32'h0000_0000;
      addr      <= 32'h0000_0000;
      wdata     <= 32'h0000_0000;
      rdata     <= 32'h0000_0000;
      divisor   <= `ONFE_DIV_RESET;
      busy      <= 1'b1;
      wrenSeen  <= 1'b0;
      rstArmed  <= 1'b0;
      phaseErr  <= 1'b0;
      divCnt    <= 8'h00;
      edgeHi    <= 1'b0;
      bitCnt    <= 3'h0;
      byteIdx   <= 4'h0;
      byteTot   <= 4'h0;
      dumCnt    <= 5'h00;
      ddrOn     <= 1'b0;
      octOn     <= 1'b0;
      rstCnt    <= 16'h0000;
      shLoad    <= 1'b0;
      shByte    <= 8'h00;
      shStep    <= 1'b0;
      flashClk  <= 1'b0;
      flashSelN <= 1'b1;
      flashRstN <= 1'b1;
      ioOut     <= 8'h00;
      ioOe      <= 8'h00;
    end else if (clkEn) begin
      shLoad <= 1'b0;
      shStep <= 1'b0;
      // register writes; refused go sets a sticky error
      if (apWrite) begin
        case (apAddr)
          `ONFE_A_CTRL:  ctrl <= hwdata[8:0];
          `ONFE_A_ADDR:  addr <= hwdata;
          `ONFE_A_WDATA: wdata <= hwdata;
          `ONFE_A_DIV:   divisor <= (hwdata[7:0] == 8'h00) ? 8'h01
                                                          : hwdata[7:0];
          `ONFE_A_STAT:  phaseErr <= phaseErr & ~hwdata[3];
          default: ;
        endcase
      end
      if (goHit && goBad) phaseErr <= 1'b1;
      case (state)
        // deselect with clock parked before first access
        S_DESEL: begin
          flashSelN <= 1'b1;
          flashClk  <= ctrl[`ONFE_C_MODE3];
          divCnt    <= divCnt + 8'h01;
          if (tick) begin
            busy   <= 1'b0;
            state  <= S_IDLE;
            divCnt <= 8'h00;
          end
        end
        S_IDLE: begin
          flashClk <= ctrl[`ONFE_C_MODE3];
          ioOe     <= {5'h00, ctrl[`ONFE_C_WPN], 2'h0}; // guard on line 2
          ioOut    <= 8'h00;
          if (apWrite && apAddr == `ONFE_A_CTRL && hwdata[`ONFE_C_HWRST]) begin
            flashRstN <= 1'b0;
            rstCnt    <= 16'h0000;
            busy      <= 1'b1;
            state     <= S_HWRST;
          end else if (goHit && !goBad) begin
            cmd      <= hwdata;
            busy     <= 1'b1;
            // opcode single line unless ONFE_C_OPC8 is set; double-rate needs ONFE_C_OPC8 and ONFE_C_DDR
            octOn    <= ctrl[`ONFE_C_OPC8];
            ddrOn    <= ctrl[`ONFE_C_DDR] && ctrl[`ONFE_C_OPC8];
            byteIdx  <= 4'h0;
            byteTot  <= 4'h1 + {1'b0, hwdata[`ONFE_K_ALEN]}
                        + {1'b0, hwdata[`ONFE_K_DLEN]};
            dumCnt   <= hwdata[`ONFE_K_DUMMY];
            bitCnt   <= 3'h0;
            edgeHi   <= ctrl[`ONFE_C_MODE3];
            shLoad   <= 1'b1;
            shByte   <= hwdata[7:0];
            // first bit must stand before the first rising edge
            ioOut    <= ctrl[`ONFE_C_OPC8] ? hwdata[7:0] : {7'h00, hwdata[7]};
            ioOe     <= ctrl[`ONFE_C_OPC8] ? 8'hFF : 8'h01;
            flashSelN <= 1'b0;
            divCnt   <= 8'h00;
            state    <= S_XFER;
            // host-side tracking of latch and reset pairing
            if (goOp == `ONFE_OP_WREN) wrenSeen <= 1'b1;
            else if (isWriteOp(goOp)) wrenSeen <= 1'b0;
            rstArmed <= (goOp == `ONFE_OP_RSTEN);
            if (goOp == `ONFE_OP_DEVRST || goOp == `ONFE_OP_RST)
              wrenSeen <= 1'b0;
          end
        end
        S_XFER: begin
          divCnt <= tick ? 8'h00 : divCnt + 8'h01;
          if (tick) begin
            flashClk <= ~flashClk;
            edgeHi   <= ~edgeHi;
            // falling edge: present next lanes; rising: sample
            if (edgeHi || ddrOn) begin
              if (!inRead || dumCnt != 5'h00) begin
                ioOut <= txLanes;
                ioOe  <= octOn ? 8'hFF : 8'h01;
              end else begin
                ioOe  <= 8'h00;
              end
            end
            if (!edgeHi || ddrOn) begin
              shStep <= 1'b1;
              bitCnt <= octOn ? 3'h7 : bitCnt + 3'h1;
              if (octOn || bitCnt == 3'h7) begin
                bitCnt  <= 3'h0;
                byteIdx <= byteIdx + 4'h1;
                // after the opcode the ctrl register picks lanes and rate
                octOn  <= (ctrl[`ONFE_C_LANES] == `ONFE_L_EIGHT);
                ddrOn  <= ctrl[`ONFE_C_DDR];
                if (inRead) begin
                  rdata <= {rdata[23:0], rxNow};
                end
                shLoad <= 1'b1;
                shByte <= frameByte(byteIdx + 4'h1, aLen, cmd, addr, wdata);
                if (byteIdx + 4'h1 == {1'b0, aLen} + 4'h1 &&
                    dumCnt != 5'h00) begin
                  dumCnt  <= dumCnt - 5'h01;
                  byteIdx <= byteIdx;
                end
                if (byteIdx + 4'h1 == byteTot) state <= S_END;
              end
            end
          end
        end
        // park clock and deselect; device busy handled by software
        S_END: begin
          divCnt <= tick ? 8'h00 : divCnt + 8'h01;
          if (tick) begin
            flashClk  <= ctrl[`ONFE_C_MODE3];
            ioOe      <= 8'h00;
            // clock parks one tick before the select edge in mode 0
            if (flashClk == ctrl[`ONFE_C_MODE3]) begin
              flashSelN <= 1'b1;
              busy      <= 1'b0;
              state     <= S_IDLE;
            end
          end
        end
        // hold reset pin low for at least the minimum pulse
        S_HWRST: begin
          rstCnt <= rstCnt + 16'h0001;
          if (rstCnt >= RST_CYC[15:0]) begin
            flashRstN <= 1'b1;
            wrenSeen  <= 1'b0;
            state     <= S_DESEL;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule

// ===== onfe_defs.vh
// onfe_defs.vh : constants for the serial NAND host front end.
// assumes: included by bare name from the host, shifter, checker and bench files.
`ifndef ONFE_DEFS_VH
`define ONFE_DEFS_VH
// =====================================================================
// register offsets (byte addresses, one word each)
`define ONFE_A_CTRL     8'h00
`define ONFE_A_CMD      8'h04
`define ONFE_A_ADDR     8'h08
`define ONFE_A_WDATA    8'h0C
`define ONFE_A_STAT     8'h10
`define ONFE_A_RDATA    8'h14
`define ONFE_A_DIV      8'h18
// =====================================================================
// ctrl fields
`define ONFE_C_MODE3    0
`define ONFE_C_LANES    2:1
`define ONFE_C_DDR      3
`define ONFE_C_OPC8     4
`define ONFE_C_HWRST    5
`define ONFE_C_WPN      6
`define ONFE_C_STROBE   7
`define ONFE_C_WIDTH    8
// cmd fields
`define ONFE_K_ALEN     10:8
`define ONFE_K_DUMMY    15:11
`define ONFE_K_DLEN     18:16
`define ONFE_K_READ     19
`define ONFE_K_GO       31
// lane codes
`define ONFE_L_ONE      2'h0
`define ONFE_L_EIGHT    2'h1
// =====================================================================
// opcodes and configuration values
`define ONFE_OP_DEVRST  8'hFF
`define ONFE_OP_RSTEN   8'h66
`define ONFE_OP_RST     8'h99
`define ONFE_OP_WREN    8'h06
`define ONFE_OP_FRO     8'h8B
`define ONFE_OP_FRIO    8'hCB
`define ONFE_OP_DDRO    8'h9D
`define ONFE_CFG_SDR_A  8'hFF
`define ONFE_CFG_SDR_B  8'hDF
`define ONFE_CFG_DDR_S  8'hE7
`define ONFE_CFG_DDR_N  8'hC7
// =====================================================================
// timing
`define ONFE_RST_PULSE_NS 1000
`define ONFE_CLK_NS       40
`define ONFE_DIV_RESET    8'h04
`endif

// ===== onfe_sync.v
// onfe_sync.v : two-flop synchroniser for a vector of pin inputs.
// assumes: inputs are asynchronous to clk; first stage read by second only.
`timescale 1ns/1ps
// =====================================================================
// synchroniser
module onfe_sync #(
  parameter W = 1
) (
  // clock and reset
  input  wire         clk,
  input  wire         rstN,
  input  wire         ce,
  // data
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] stage1;
  // two stages; reset to zero keeps outputs defined
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      stage1 <= {W{1'b0}};
      dout   <= {W{1'b0}};
    end else if (ce) begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule

// ===== onfe_shift.v
// onfe_shift.v : byte serialiser/deserialiser for one, or eight lanes.
// assumes: load/step pulses come from the controller on the same clock.
`timescale 1ns/1ps
`include "onfe_defs.vh"
// =====================================================================
// shifter
module onfe_shift (
  // clock and reset
  input  wire       clk,
  input  wire       rstN,
  input  wire       ce,
  // control
  input  wire       load,
  input  wire [7:0] loadByte,
  input  wire       octal,
  input  wire       step,
  input  wire [7:0] sampleIn,
  // outputs
  output reg  [7:0] txLanes,
  output reg  [7:0] rxByte
);
  reg [7:0] tx;
  // load replaces the byte; step moves one bit or one whole byte
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      tx     <= 8'h00;
      rxByte <= 8'h00;
    end else if (ce) begin
      if (load) begin
        tx <= loadByte;
      end else if (step) begin
        tx     <= octal ? 8'h00 : {tx[6:0], 1'b0};
        rxByte <= octal ? sampleIn : {rxByte[6:0], sampleIn[1]};
      end
    end
  end
  // lane view: msb on lane 0 in single mode, whole byte in octal
  always @* begin
    txLanes = octal ? tx : {7'h00, tx[7]};
  end
endmodule

// ===== onfe_host_props.sv
// onfe_host_props.sv : port checks for the serial nand host front end.
// assumes: bound to onfe_host; sees only its ports.
`timescale 1ns/1ps
`include "onfe_defs.vh"
// ====================================================================
// checker
module onfe_host_props #(
  parameter RST_NS = `ONFE_RST_PULSE_NS
) (
  // clock and reset
  input logic       ref_clk,
  input logic       arst_n,
  // bus response
  input logic       hresp,
  // device pins
  input logic       flashClk,
  input logic       flashSelN,
  input logic       flashRstN,
  input logic [7:0] ioOut,
  input logic [7:0] ioOe
);
  localparam int RstCyc = RST_NS / `ONFE_CLK_NS;
  logic [15:0] lowCnt;
  logic [3:0]  riseCnt;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // ==================================================================
  // helpers: saturating counters so a long run cannot wrap them
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lowCnt  <= 16'h0000;
      riseCnt <= 4'h0;
    end else begin
      lowCnt <= flashRstN ? 16'h0000 : lowCnt + {15'h0000, ~&lowCnt};
      if (flashSelN)
        riseCnt <= 4'h0;
      else if ($rose(flashClk) && riseCnt != 4'hF)
        riseCnt <= riseCnt + 4'h1;
    end
  end
  // ==================================================================
  // properties
  property p_okay;
    hresp == 1'h0;
  endproperty
  a_okay: assert property (p_okay) else $error("bus response not okay");
  property p_clkAtSel;
    $changed(flashSelN) |-> $stable(flashClk);
  endproperty
  a_clkAtSel: assert property (p_clkAtSel)
    else $error("link clock moved at a select edge");
  property p_deselFirst;
    $rose(arst_n) |-> flashSelN [*4];
  endproperty
  a_deselFirst: assert property (p_deselFirst)
    else $error("device selected too soon after reset");
  property p_rstLong;
    $rose(flashRstN) |-> lowCnt >= RstCyc;
  endproperty
  a_rstLong: assert property (p_rstLong)
    else $error("device reset pulse too short");
  property p_selInRst;
    !flashRstN |-> flashSelN;
  endproperty
  a_selInRst: assert property (p_selInRst)
    else $error("device selected during reset pulse");
  property p_dataAtRise;
    !flashSelN && $rose(flashClk) |-> $stable(ioOut);
  endproperty
  a_dataAtRise: assert property (p_dataAtRise)
    else $error("data changed at a sampling edge");
  property p_opcodeOneLine;
    !flashSelN && riseCnt < 4'h8 |-> ioOe[7:1] == 7'h00;
  endproperty
  a_opcodeOneLine: assert property (p_opcodeOneLine)
    else $error("opcode not on one line");
  property p_idleRelease;
    flashSelN && $past(flashSelN) |-> (ioOe & 8'hFB) == 8'h00;
  endproperty
  a_idleRelease: assert property (p_idleRelease)
    else $error("data lines driven while deselected");
  // main scenarios reached
  c_pulse: cover property ($rose(flashRstN));
  c_frame: cover property ($fell(flashSelN));
  c_mode3: cover property ($fell(flashSelN) && flashClk);
endmodule

// ===== onfe_dev_model.sv
// onfe_dev_model.sv : behavioural serial nand device for the bench.
// assumes: host drives pins; single-line replies only.
`timescale 1ns/1ps
// ====================================================================
// device model
module onfe_dev_model (
  // pins from host
  input  logic       flashClk,
  input  logic       flashSelN,
  input  logic       flashRstN,
  input  logic [7:0] ioOut,
  // pins to host
  output logic [7:0] ioIn,
  output logic       strobeIn,
  // bench side
  input  logic [7:0] txByte,
  output logic [7:0] lastOp,
  output logic       write_enable_latch
);
  localparam int LockNs = 2000; // lockout length, arbitrary
  logic [4:0] bitCnt;
  logic [7:0] sh;
  logic       locked;
  // power-up: write-disabled, nothing decoded yet
  initial begin
    locked   = 1'h1;
    ioIn     = 8'h5A;
    strobeIn = 1'h0;
    lastOp   = 8'h00;
    sh       = 8'h00;
    write_enable_latch      = 1'h0;
    bitCnt   = 5'h00;
    #(LockNs) locked = 1'h0;
  end
  // same lockout again once the reset pin lets go
  always @(posedge flashRstN) begin
    locked = 1'h1;
    #(LockNs) locked = 1'h0;
  end
  // reset pin beats everything and clears the write latch and the bit count
  always @(negedge flashRstN) begin
    write_enable_latch    = 1'h0;
    bitCnt = 5'h00;
  end
  // a frame starts only on a select edge
  always @(negedge flashSelN) bitCnt = 5'h00;
  // released lines float: show the inverse, never the last value
  always @(posedge flashSelN) begin
    ioIn     = ~ioIn;
    strobeIn = ~strobeIn;
  end
  // opcode on line 0 at rising edges
  always @(posedge flashClk) begin
    if (!flashSelN && flashRstN) begin
      if (bitCnt < 5'h08) sh = {sh[6:0], ioOut[0]};
      if (bitCnt < 5'h1F) bitCnt = bitCnt + 5'h01;
      if (bitCnt == 5'h08) begin
        lastOp = sh;
        strobeIn = 1'h0;
        if (sh == 8'h06 && !locked) write_enable_latch = 1'h1;
        if (sh == 8'hFF || sh == 8'h99) write_enable_latch = 1'h0;
        if (sh == 8'h10 || sh == 8'hD8) write_enable_latch = 1'h0;
      end
    end
  end
  // reply on line 1 at falling edges, msb first
  always @(negedge flashClk) begin
    if (!flashSelN && bitCnt >= 5'h08 && bitCnt < 5'h10) begin
      ioIn[1]  = txByte[5'h0F - bitCnt];
      strobeIn = ~strobeIn;
    end
  end
endmodule

// ===== test_onfe_host.sv
// test_onfe_host.sv : self-checking bench for the nand host front end.
// assumes: host, device model and checker compiled before this file.
`timescale 1ns/1ps
`include "onfe_defs.vh"
// ====================================================================
// bench top
module test_onfe_host;
  typedef struct {
    logic [31:0] mask;
    logic [31:0] exp;
    string       name;
  } onfe_note_t;
  localparam int RstCyc = 1000 / `ONFE_CLK_NS;
  logic        ref_clk = 1'h0;
  logic        arst_n  = 1'h0;
  logic        hsel    = 1'h0;
  logic        hwrite  = 1'h0;
  logic [7:0]  haddr   = 8'h00;
  logic [1:0]  htrans  = 2'h0;
  logic [31:0] hwdata  = 32'h0;
  logic [7:0]  txByte  = 8'h00;
  logic        rdPend  = 1'h0;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  wire         flashClk;
  wire         flashSelN;
  wire         flashRstN;
  wire  [7:0]  ioOut;
  wire  [7:0]  ioOe;
  wire  [7:0]  ioIn;
  wire         strobeIn;
  wire  [7:0]  lastOp;
  wire         write_enable_latch;
  onfe_note_t  notes[$];
  onfe_note_t  note;
  int          miscompares = 0;
  int          tests_run   = 0;
  int          cnt;
  logic [31:0] r;
  always #20 ref_clk = ~ref_clk;
  onfe_host #(.RST_NS(1000)) onfe_host_inst (
    .ref_clk, .arst_n, .clkEn(1'h1), .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .flashClk, .flashSelN, .flashRstN, .ioOut, .ioOe, .ioIn,
    .strobeIn
  );
  onfe_dev_model onfe_dev_model_inst (
    .flashClk, .flashSelN, .flashRstN, .ioOut, .ioIn, .strobeIn,
    .txByte, .lastOp, .write_enable_latch
  );
  // ==================================================================
  // shared tasks
  task automatic cmpVal(input string n, input logic [31:0] e,
                        input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // one single word transfer; address held until hready
  task automatic busCycle(input logic [7:0] a, input logic wr,
                          input logic [31:0] d, output logic [31:0] v);
    @(posedge ref_clk);
    hsel   <= 1'h1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge ref_clk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'h1);
    v = hrdata;
  endtask
  // every read leaves a note; mask zero means no comparison
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e, input string n,
                    output logic [31:0] v);
    notes.push_back('{m, e, n});
    busCycle(a, 1'h0, 32'h0, v);
  endtask
  task automatic waitIdle;
    logic [31:0] s;
    s = 32'h1;
    repeat (500) if (s[0] !== 1'h0) rd(`ONFE_A_STAT, 32'h0, 32'h0, "", s);
    // polls running out count as a hang
    if (s[0] !== 1'h0) begin
      miscompares++;
      $display("wrong value busy expected 0 seen %h", s[0]);
    end
  endtask
  // issue a command, check the refusal flag, then clear it
  task automatic tryOp(input logic [31:0] c, input logic err);
    busCycle(`ONFE_A_CMD, 1'h1, c, r);
    waitIdle;
    rd(`ONFE_A_STAT, 32'h8, {28'h0, err, 3'h0}, "refusal flag", r);
    busCycle(`ONFE_A_STAT, 1'h1, 32'h8, r);
    $display("test op %h done", c[7:0]);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ==================================================================
  // monitor: oldest note against read data as each read completes
  always @(posedge ref_clk) begin
    if (rdPend && hreadyout === 1'h1) begin
      note = notes.pop_front();
      if (note.mask !== 32'h0) cmpVal(note.name, note.exp, hrdata & note.mask);
    end
    rdPend <= hsel && hreadyout && htrans[1] && !hwrite;
  end
  // watchdog well beyond the expected thousand or so cycles
  initial begin
    repeat (60000) @(posedge ref_clk);
    miscompares++;
    print_verdict;
  end
  // ==================================================================
  // main sequence
  initial begin
    void'($urandom(32'hAC01F842));
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'h1;
    // the bus is deaf until the reset copy has gone through its flops
    repeat (4) @(posedge ref_clk);
    waitIdle;
    rd(`ONFE_A_DIV, 32'hFF, {24'h0, `ONFE_DIV_RESET}, "divisor", r);
    tryOp(32'h80000002, 1'h1);
    cmpVal("opcode seen", 32'h0, {24'h0, lastOp});
    tryOp(32'h80000099, 1'h1);
    tryOp(32'h80000066, 1'h0);
    tryOp(32'h80000099, 1'h0);
    cmpVal("opcode seen", 32'h99, {24'h0, lastOp});
    tryOp(32'h80000006, 1'h0);
    rd(`ONFE_A_STAT, 32'h2, 32'h2, "latch seen", r);
    cmpVal("device latch", 32'h1, {31'h0, write_enable_latch});
    // clock mode 0 then mode 3, random reply byte each time
    for (int m = 0; m < 2; m++) begin
      busCycle(`ONFE_A_CTRL, 1'h1, 32'(m), r);
      txByte <= 8'($urandom);
      tryOp(32'h8009000F, 1'h0);
      rd(`ONFE_A_RDATA, 32'hFF, {24'h0, txByte}, "read", r);
    end
    // octal read refused while the guard pin is held
    busCycle(`ONFE_A_CTRL, 1'h1, 32'h42, r);
    tryOp(32'h8009008B, 1'h1);
    busCycle(`ONFE_A_CTRL, 1'h1, 32'h2, r);
    tryOp(32'h800900CB, 1'h0);
    cmpVal("opcode seen", 32'hCB, {24'h0, lastOp});
    // hardware reset pulse length
    busCycle(`ONFE_A_CTRL, 1'h1, 32'h20, r);
    cnt = 0;
    repeat (100) begin
      @(posedge ref_clk);
      if (flashRstN === 1'h0) cnt++;
    end
    cmpVal("reset low", 32'h1, {31'h0, cnt >= RstCyc});
    waitIdle;
    rd(`ONFE_A_STAT, 32'h2, 32'h0, "latch after reset", r);
    cmpVal("device latch", 32'h0, {31'h0, write_enable_latch});
    $display("test reset pulse done");
    busCycle(`ONFE_A_CTRL, 1'h1, 32'h0, r);
    print_verdict;
  end
endmodule
bind onfe_host onfe_host_props #(.RST_NS(RST_NS)) onfe_host_props_inst (
  .ref_clk(ref_clk), .arst_n(arst_n), .hresp(hresp), .flashClk(flashClk),
  .flashSelN(flashSelN), .flashRstN(flashRstN), .ioOut(ioOut), .ioOe(ioOe)
);
